// ### rtl/ptp_cfg_defines.svh
// Register offsets, field positions, reset values and fixed addresses of the Port 2 capture setup
`ifndef PTP_CFG_DEFINES_SVH
`define PTP_CFG_DEFINES_SVH

`define REG_ADDR_W 12
`define OFS_AUX_ADDR_HIGH 12'h18C
`define OFS_AUX_ADDR_LOW 12'h190
`define OFS_TS_CONFIG 12'h194

`define BIT_P2_MASTER_SELECT 31
`define BIT_P2_PRIMARY_EN 30
`define BIT_P2_ALT1_EN 29
`define BIT_P2_ALT2_EN 28
`define BIT_P2_ALT3_EN 27
`define BIT_P2_AUX_EN 26
`define BIT_P2_LOCK_RX 25
`define BIT_P2_LOCK_TX 24

`define P2_FIELD_HI 31
`define P2_FIELD_LO 24
`define P2_FIELD_RESET 8'h43
`define AUX_HIGH_W 16
`define AUX_HIGH_RESET 16'h0000
`define AUX_LOW_RESET 32'h00000000

`define PTP_ADDR_PRIMARY 48'h01005E000181
`define PTP_ADDR_ALT1 48'h01005E000182
`define PTP_ADDR_ALT2 48'h01005E000183
`define PTP_ADDR_ALT3 48'h01005E000184
`define PTP_FIXED_ADDRS 4

`endif

// ### rtl/ptp_cfg_pkg.sv
// Types shared by the Port 2 capture setup logic
package ptp_cfg_pkg;

    typedef struct packed {
        logic valid;
        logic is_tx;
        logic is_sync;
        logic is_delay_req;
        logic [47:0] dst_addr;
        logic [15:0] seq_id;
        logic [79:0] source_port_identity;
        logic [63:0] stamp;
    } ptp_frame_t;

    typedef struct packed {
        logic [63:0] stamp;
        logic [79:0] source_port_identity;
        logic [15:0] seq_id;
    } capture_t;

    typedef struct packed {
        logic port2_master_select;
        logic port2_primary_addr_enable;
        logic port2_alternate_addr1_enable;
        logic port2_alternate_addr2_enable;
        logic port2_alternate_addr3_enable;
        logic port2_auxiliary_addr_enable;
        logic port2_lock_rx;
        logic port2_lock_tx;
    } port2_cfg_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

// ### rtl/port2_addr_match.sv
// Registered PTP destination address classifier for Port 2 frames
`timescale 1ns/1ps
`include "ptp_cfg_defines.svh"

module port2_addr_match (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [4:0] addr_enable,
    input wire logic [47:0] auxiliary_addr,
    input wire ptp_cfg_pkg::ptp_frame_t frame_in,
    output ptp_cfg_pkg::ptp_frame_t frame_q,
    output logic is_ptp_q
);

    localparam logic [47:0] FIXED_ADDR [`PTP_FIXED_ADDRS] = '{
        `PTP_ADDR_PRIMARY, `PTP_ADDR_ALT1, `PTP_ADDR_ALT2, `PTP_ADDR_ALT3
    };

    logic [4:0] hit;

    // Each enable bit gates exactly one address; a disabled address never matches
    genvar g;
    generate
        for (g = 0; g < `PTP_FIXED_ADDRS; g++) begin : g_fixed
            assign hit[g] = addr_enable[g] && (frame_in.dst_addr == FIXED_ADDR[g]);
        end
    endgenerate
    assign hit[4] = addr_enable[4] && (frame_in.dst_addr == auxiliary_addr);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= '0;
            is_ptp_q <= 1'b0;
        end else if (clk_en) begin
            frame_q <= frame_in;
            is_ptp_q <= frame_in.valid && (|hit);
        end
    end

endmodule // port2_addr_match

// ### rtl/ptp_port2_capture_config.sv
// Port 2 PTP timestamp capture configuration, address filter and capture hold
`timescale 1ns/1ps
`include "ptp_cfg_defines.svh"

module ptp_port2_capture_config (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access port
    input wire ptp_cfg_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Port 2 frame events, one cycle per message
    input wire ptp_cfg_pkg::ptp_frame_t frame_in,
    // Capture flag clears from the interrupt status owner
    input wire logic rx_flag_clear,
    input wire logic tx_flag_clear,
    // Captured values, pending flags and decoded Port 2 configuration
    output ptp_cfg_pkg::capture_t rx_capture_q,
    output ptp_cfg_pkg::capture_t tx_capture_q,
    output logic rx_capture_flag_q,
    output logic tx_capture_flag_q,
    output ptp_cfg_pkg::port2_cfg_t port2_cfg
);

    logic [`P2_FIELD_HI:`P2_FIELD_LO] cfg_field_q;
    logic [`AUX_HIGH_W-1:0] aux_high_q;
    logic [31:0] aux_low_q;
    logic [47:0] auxiliary_addr;
    logic [4:0] addr_enable;

    ptp_cfg_pkg::ptp_frame_t match_frame;
    logic match_is_ptp;

    logic rx_want;
    logic tx_want;
    logic rx_take;
    logic tx_take;
    logic rx_held;
    logic tx_held;
    ptp_cfg_pkg::capture_t new_capture;

    // Byte address decode is used by both the write and read paths
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Configuration register writes
    // ------------------------------------------------------------------

    // Only bits 31:24 live here; the other ports own bits 23:0
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_field_q <= `P2_FIELD_RESET;
        end else if (clk_en && reg_req.sel && reg_req.wr
                     && reg_hit(reg_req.addr, `OFS_TS_CONFIG)) begin
            cfg_field_q <= reg_req.wdata[`P2_FIELD_HI:`P2_FIELD_LO];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_high_q <= `AUX_HIGH_RESET;
        end else if (clk_en && reg_req.sel && reg_req.wr
                     && reg_hit(reg_req.addr, `OFS_AUX_ADDR_HIGH)) begin
            aux_high_q <= reg_req.wdata[`AUX_HIGH_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_low_q <= `AUX_LOW_RESET;
        end else if (clk_en && reg_req.sel && reg_req.wr
                     && reg_hit(reg_req.addr, `OFS_AUX_ADDR_LOW)) begin
            aux_low_q <= reg_req.wdata;
        end
    end

    // High word carries the first-transmitted address octets
    assign auxiliary_addr = {aux_high_q, aux_low_q};

    // ------------------------------------------------------------------
    // Register reads: one cycle latency, unmapped offsets read zero
    // ------------------------------------------------------------------

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h00000000;
            reg_rvalid_q <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid_q <= reg_req.sel && !reg_req.wr;
            if (reg_req.sel && !reg_req.wr) begin
                if (reg_hit(reg_req.addr, `OFS_TS_CONFIG)) begin
                    reg_rdata_q <= {cfg_field_q, 24'h000000};
                end else if (reg_hit(reg_req.addr, `OFS_AUX_ADDR_HIGH)) begin
                    reg_rdata_q <= {16'h0000, aux_high_q};
                end else if (reg_hit(reg_req.addr, `OFS_AUX_ADDR_LOW)) begin
                    reg_rdata_q <= aux_low_q;
                end else begin
                    reg_rdata_q <= 32'h00000000;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Field breakout
    // ------------------------------------------------------------------

    assign port2_cfg.port2_master_select = cfg_field_q[`BIT_P2_MASTER_SELECT];
    assign port2_cfg.port2_primary_addr_enable = cfg_field_q[`BIT_P2_PRIMARY_EN];
    assign port2_cfg.port2_alternate_addr1_enable = cfg_field_q[`BIT_P2_ALT1_EN];
    assign port2_cfg.port2_alternate_addr2_enable = cfg_field_q[`BIT_P2_ALT2_EN];
    assign port2_cfg.port2_alternate_addr3_enable = cfg_field_q[`BIT_P2_ALT3_EN];
    assign port2_cfg.port2_auxiliary_addr_enable = cfg_field_q[`BIT_P2_AUX_EN];
    assign port2_cfg.port2_lock_rx = cfg_field_q[`BIT_P2_LOCK_RX];
    assign port2_cfg.port2_lock_tx = cfg_field_q[`BIT_P2_LOCK_TX];

    // Index order matches the fixed address table in the classifier
    assign addr_enable = {
        port2_cfg.port2_auxiliary_addr_enable,
        port2_cfg.port2_alternate_addr3_enable,
        port2_cfg.port2_alternate_addr2_enable,
        port2_cfg.port2_alternate_addr1_enable,
        port2_cfg.port2_primary_addr_enable
    };

    // ------------------------------------------------------------------
    // Destination address classification
    // ------------------------------------------------------------------

    // Registered so a config write lands cleanly between two frames
    port2_addr_match u_addr_match (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .addr_enable(addr_enable),
        .auxiliary_addr(auxiliary_addr),
        .frame_in(frame_in),
        .frame_q(match_frame),
        .is_ptp_q(match_is_ptp)
    );

    // ------------------------------------------------------------------
    // Message selection by role
    // ------------------------------------------------------------------

    always_comb begin
        if (port2_cfg.port2_master_select) begin
            tx_want = match_frame.is_tx && match_frame.is_sync;
            rx_want = !match_frame.is_tx && match_frame.is_delay_req;
        end else begin
            tx_want = match_frame.is_tx && match_frame.is_delay_req;
            rx_want = !match_frame.is_tx && match_frame.is_sync;
        end
    end

    assign rx_take = match_is_ptp && rx_want;
    assign tx_take = match_is_ptp && tx_want;

    // A pending flag only protects the values when its lock bit is set
    assign rx_held = port2_cfg.port2_lock_rx && rx_capture_flag_q;
    assign tx_held = port2_cfg.port2_lock_tx && tx_capture_flag_q;

    assign new_capture.stamp = match_frame.stamp;
    assign new_capture.source_port_identity = match_frame.source_port_identity;
    assign new_capture.seq_id = match_frame.seq_id;

    // ------------------------------------------------------------------
    // Capture storage
    // ------------------------------------------------------------------

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_capture_q <= '0;
        end else if (clk_en && rx_take && !rx_held) begin
            rx_capture_q <= new_capture;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_capture_q <= '0;
        end else if (clk_en && tx_take && !tx_held) begin
            tx_capture_q <= new_capture;
        end
    end

    // ------------------------------------------------------------------
    // Capture pending flags: a new capture wins over a clear
    // ------------------------------------------------------------------

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_capture_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_take) begin
                rx_capture_flag_q <= 1'b1;
            end else if (rx_flag_clear) begin
                rx_capture_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_capture_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (tx_take) begin
                tx_capture_flag_q <= 1'b1;
            end else if (tx_flag_clear) begin
                tx_capture_flag_q <= 1'b0;
            end
        end
    end

endmodule // ptp_port2_capture_config

// ### tb/ptp_port2_capture_checker.sv
// Port-level assertions for the Port 2 capture setup
`timescale 1ns/1ps
module ptp_port2_capture_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire ptp_cfg_pkg::reg_req_t reg_req,
    input wire logic [31:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire ptp_cfg_pkg::ptp_frame_t frame_in,
    input wire logic rx_flag_clear,
    input wire logic tx_flag_clear,
    input wire ptp_cfg_pkg::capture_t rx_capture_q,
    input wire ptp_cfg_pkg::capture_t tx_capture_q,
    input wire logic rx_capture_flag_q,
    input wire logic tx_capture_flag_q,
    input wire ptp_cfg_pkg::port2_cfg_t port2_cfg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic cfg_hit;
    logic ms;
    assign cfg_hit = clk_en && reg_req.sel && reg_req.addr == 12'h194;
    assign ms = port2_cfg.port2_master_select;
    // A frozen clock enable holds the read strobe as it was
    rd_valid_a: assert property (
        reg_rvalid_q == ($past(clk_en) ? $past(reg_req.sel && !reg_req.wr)
                                       : $past(reg_rvalid_q)))
        else $error("read strobe without a read");
    rd_data_a: assert property (
        cfg_hit && !reg_req.wr |=> reg_rdata_q == {$past(port2_cfg), 24'h0})
        else $error("config readback wrong");
    cfg_write_a: assert property (
        cfg_hit && reg_req.wr |=> port2_cfg == $past(reg_req.wdata[31:24]))
        else $error("config write not applied");
    rx_lock_a: assert property (
        clk_en && rx_capture_flag_q && port2_cfg.port2_lock_rx |=> $stable(rx_capture_q))
        else $error("locked rx capture overwritten");
    tx_lock_a: assert property (
        clk_en && tx_capture_flag_q && port2_cfg.port2_lock_tx |=> $stable(tx_capture_q))
        else $error("locked tx capture overwritten");
    rx_cause_a: assert property ($rose(rx_capture_flag_q) |->
        $past(frame_in.valid && !frame_in.is_tx
              && (ms ? frame_in.is_delay_req : frame_in.is_sync), 2))
        else $error("rx flag without a matching message");
    tx_cause_a: assert property ($rose(tx_capture_flag_q) |->
        $past(frame_in.valid && frame_in.is_tx
              && (ms ? frame_in.is_sync : frame_in.is_delay_req), 2))
        else $error("tx flag without a matching message");
    rx_clear_a: assert property (
        clk_en && rx_capture_flag_q && rx_flag_clear && !$past(frame_in.valid)
        |=> !rx_capture_flag_q)
        else $error("rx flag not cleared");
    tx_clear_a: assert property (
        clk_en && tx_capture_flag_q && tx_flag_clear && !$past(frame_in.valid)
        |=> !tx_capture_flag_q)
        else $error("tx flag not cleared");
    cover property (cfg_hit && !reg_req.wr);
    cover property (!clk_en && frame_in.valid);
    cover property (rx_capture_flag_q && port2_cfg.port2_lock_rx && frame_in.valid);
    cover property ($rose(tx_capture_flag_q));
endmodule // ptp_port2_capture_checker

bind ptp_port2_capture_config ptp_port2_capture_checker u_ptp_port2_capture_checker (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .frame_in(frame_in),
    .rx_flag_clear(rx_flag_clear), .tx_flag_clear(tx_flag_clear),
    .rx_capture_q(rx_capture_q), .tx_capture_q(tx_capture_q),
    .rx_capture_flag_q(rx_capture_flag_q), .tx_capture_flag_q(tx_capture_flag_q),
    .port2_cfg(port2_cfg));

// ### tb/ptp_frame_src.sv
// Port 2 traffic model: one PTP message per call as a one-cycle event
`timescale 1ns/1ps
module ptp_frame_src (
    input wire logic core_clk,
    output ptp_cfg_pkg::ptp_frame_t frame
);
    initial frame = '0;
    task automatic send(input logic tx, input logic sy, input logic [47:0] da,
                        input logic [15:0] seq);
        @(negedge core_clk);
        frame = '{1'b1, tx, sy, !sy, da, seq, {5{seq}}, {4{seq}}};
        @(negedge core_clk);
        // Stale fields are scrambled so nothing can lean on old values
        frame = {1'b0, ~frame[$bits(frame)-2:0]};
    endtask
endmodule // ptp_frame_src

// ### tb/tb_ptp_port2_capture_config.sv
// Self-checking bench for the Port 2 capture setup
`timescale 1ns/1ps
`include "ptp_cfg_defines.svh"
module tb_ptp_port2_capture_config;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_clr = 1'b0;
    logic tx_clr = 1'b0;
    ptp_cfg_pkg::reg_req_t reg_req = '0;
    ptp_cfg_pkg::ptp_frame_t frame_in;
    logic [31:0] rdata;
    ptp_cfg_pkg::capture_t rx_cap, tx_cap;
    logic rx_flag, tx_flag;
    logic clk_en = 1'b1;
    logic rvalid;
    ptp_cfg_pkg::port2_cfg_t p2_cfg;
    int err_count = 0;
    int total_checks = 0;
    logic [47:0] addrs [5];
    always #50 core_clk = ~core_clk;
    ptp_frame_src u_ptp_frame_src (.core_clk(core_clk), .frame(frame_in));
    ptp_port2_capture_config u_ptp_port2_capture_config (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .frame_in(frame_in),
        .rx_flag_clear(rx_clr), .tx_flag_clear(tx_clr), .rx_capture_q(rx_cap),
        .tx_capture_q(tx_cap), .rx_capture_flag_q(rx_flag), .tx_capture_flag_q(tx_flag),
        .port2_cfg(p2_cfg));
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(negedge core_clk);
        reg_req = '{1'b1, wr, a, d};
        @(negedge core_clk);
        reg_req.sel = 1'b0;
    endtask
    task automatic cfg(input logic [7:0] b);
        reg_acc(1'b1, `OFS_TS_CONFIG, {b, 24'h0});
    endtask
    task automatic clr();
        @(negedge core_clk);
        rx_clr = 1'b1;
        tx_clr = 1'b1;
        @(negedge core_clk);
        rx_clr = 1'b0;
        tx_clr = 1'b0;
    endtask
    // Returns once the capture stage has had its edge
    task automatic snd(input logic tx, input logic sy, input logic [47:0] da,
                       input logic [15:0] seq);
        u_ptp_frame_src.send(tx, sy, da, seq);
        @(negedge core_clk);
    endtask
    task automatic t_regs();
        reg_acc(1'b0, `OFS_TS_CONFIG, 32'h0);
        chk(rdata, 32'h43000000);
        chk(rvalid, 1'b1);
        chk(p2_cfg, 8'h43);
        reg_acc(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h0);
        reg_acc(1'b1, `OFS_AUX_ADDR_HIGH, 32'hFFFF0A1B);
        reg_acc(1'b1, `OFS_AUX_ADDR_LOW, 32'h2C3D4E5F);
        chk(rvalid, 1'b0);
        reg_acc(1'b0, `OFS_AUX_ADDR_HIGH, 32'h0);
        chk(rdata, 32'h00000A1B);
        reg_acc(1'b0, `OFS_AUX_ADDR_LOW, 32'h0);
        chk(rdata, 32'h2C3D4E5F);
    endtask
    // Each address alone, then its neighbour must miss
    task automatic t_addr();
        for (int i = 0; i < 5; i++) begin
            cfg(8'(8'h40 >> i));
            snd(1'b0, 1'b1, addrs[i], 16'(i + 1));
            chk(rx_flag, 1'b1);
            chk(rx_cap.seq_id, 16'(i + 1));
            clr();
            snd(1'b0, 1'b1, addrs[(i + 1) % 5], 16'h00FF);
            chk(rx_flag, 1'b0);
        end
    endtask
    task automatic t_role();
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                cfg(m[0] ? 8'hC0 : 8'h40);
                snd(k[1], k[0], `PTP_ADDR_PRIMARY, 16'h0077);
                chk(k[1] ? tx_flag : rx_flag, (k[1] == k[0]) == m[0]);
                chk(k[1] ? rx_flag : tx_flag, 1'b0);
                clr();
            end
        end
    endtask
    task automatic t_lock();
        logic [15:0] e;
        for (int d = 0; d < 2; d++) begin
            for (int lk = 0; lk < 2; lk++) begin
                e = lk[0] ? 16'h0010 : 16'h0011;
                cfg(lk[0] ? (d[0] ? 8'h41 : 8'h42) : 8'h40);
                snd(d[0], !d[0], `PTP_ADDR_PRIMARY, 16'h0010);
                snd(d[0], !d[0], `PTP_ADDR_PRIMARY, 16'h0011);
                chk(d[0] ? tx_cap.seq_id : rx_cap.seq_id, e);
                chk(d[0] ? tx_cap.stamp : rx_cap.stamp, {4{e}});
                chk(d[0] ? tx_cap.source_port_identity : rx_cap.source_port_identity,
                    {5{e}});
                chk(d[0] ? tx_flag : rx_flag, 1'b1);
                clr();
                // Once the flag is cleared the lock lets the next capture in
                snd(d[0], !d[0], `PTP_ADDR_PRIMARY, 16'h0012);
                chk(d[0] ? tx_cap.seq_id : rx_cap.seq_id, 16'h0012);
                clr();
            end
        end
    endtask
    // Frozen clock enable, then a capture meeting a clear in one cycle
    task automatic t_hold();
        @(negedge core_clk);
        clk_en = 1'b0;
        cfg(8'hFF);
        snd(1'b0, 1'b1, `PTP_ADDR_PRIMARY, 16'h00AA);
        clk_en = 1'b1;
        chk(p2_cfg, 8'h41);
        chk(rx_flag, 1'b0);
        chk(rx_cap.seq_id, 16'h0012);
        fork
            snd(1'b0, 1'b1, `PTP_ADDR_PRIMARY, 16'h00BB);
            begin
                repeat (2) @(negedge core_clk);
                rx_clr = 1'b1;
                @(negedge core_clk);
                rx_clr = 1'b0;
            end
        join
        chk(rx_flag, 1'b1);
        chk(rx_cap.seq_id, 16'h00BB);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        addrs = '{`PTP_ADDR_PRIMARY, `PTP_ADDR_ALT1, `PTP_ADDR_ALT2, `PTP_ADDR_ALT3,
                  48'h0A1B2C3D4E5F};
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        t_regs();
        t_addr();
        t_role();
        t_lock();
        t_hold();
        close_out();
    end
    // About 200 cycles expected; allow fifteen times that
    initial begin
        #300000;
        err_count++;
        close_out();
    end
endmodule // tb_ptp_port2_capture_config
